// ---- cuo_pkg.sv ----
// constants shared by the compare and pwm output unit
package cuo_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADR_CTL = 3'h0; // unit_control
  localparam logic [2:0] ADR_CVL = 3'h1; // compare_value_low
  localparam logic [2:0] ADR_CVH = 3'h2; // compare_value_high
  localparam logic [2:0] ADR_IEN = 3'h3; // peripheral_irq_enable_one
  localparam logic [2:0] ADR_FLG = 3'h4; // peripheral_irq_flags_one
  localparam logic [2:0] ADR_PER = 3'h5; // pwm_period_value
  localparam logic [2:0] ADR_TBC = 3'h6; // timer_b_control
  localparam logic [2:0] ADR_TBV = 3'h7; // timer_b_count
  // flag and enable bit positions
  localparam int FLG_TA = 0; // timer_a_overflow_flag
  localparam int FLG_TB = 1; // timer b period match flag
  localparam int FLG_UNIT = 2; // unit_event_flag
  // unit_control and timer_b_control fields
  localparam int DLB_LO = 4; // duty_low_bits lsb
  localparam int TBC_ON = 2; // timer b run bit
  // mode_select_field encodings
  localparam logic [3:0] MD_OFF = 4'h0; // unit off
  localparam logic [3:0] MD_TOG = 4'h2; // toggle on match
  localparam logic [3:0] MD_SET = 4'h8; // set on match
  localparam logic [3:0] MD_CLR = 4'h9; // clear on match
  localparam logic [3:0] MD_SWI = 4'ha; // software event only
  localparam logic [3:0] MD_TRG = 4'hb; // special trigger
  localparam logic [1:0] MD_PWM = 2'h3; // pwm when top bits are 11
  // timer b sub counter limits: 4 phases times prescale
  localparam logic [5:0] SUB_P1 = 6'h03; // prescale 1
  localparam logic [5:0] SUB_P4 = 6'h0f; // prescale 4
  localparam logic [5:0] SUB_P16 = 6'h3f; // prescale 16
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00; // all registers but the period register clear
  localparam logic [7:0] RST_PER = 8'hff; // period register
endpackage : cuo_pkg

// ---- cuo_unit.sv ----
// compare and pwm output unit with its register file and timer b
`timescale 1ns/1ns
`default_nettype none
module cuo_unit (
  input wire logic clock, // system clock, 125 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [2:0] addr, // register index
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic [15:0] timer_a_count, // timer a count pair
  input wire logic timer_a_tick, // timer a clock rising edge
  input wire logic timer_a_ovf, // timer a rollover pulse
  input wire logic adc_enable, // converter is enabled
  input wire logic sleep, // system clock stopped
  output logic timer_a_clear, // clear timer a, one pulse
  output logic special_trigger, // trigger pulse on match
  output logic adc_start, // conversion request pulse
  output logic unit_irq, // interrupt request level
  output logic pin_out, // output_unit pin level
  output logic pin_oe // high while unit drives pin
);
  // register file
  logic [7:0] ctl_r, ctl_nxt; // unit_control
  logic [7:0] cvl_r, cvl_nxt; // compare_value_low
  logic [7:0] cvh_r, cvh_nxt; // compare_value_high
  logic [7:0] ien_r, ien_nxt; // irq enables
  logic [7:0] flg_r, flg_nxt; // irq flags
  logic [7:0] per_r, per_nxt; // pwm_period_value
  logic [7:0] tbc_r, tbc_nxt; // timer_b_control
  logic [7:0] rdata_r, rdata_nxt; // read data
  // timer b and pwm state
  logic [7:0] tmrb_r, tmrb_nxt; // timer_b_count
  logic [5:0] sub_r, sub_nxt; // phase and prescale counter
  logic [1:0] dlat_r, dlat_nxt; // latched duty low bits
  logic pwm_r, pwm_nxt; // pwm pin level
  // compare state
  logic cmp_r, cmp_nxt; // compare output latch
  logic eqp_r, eqp_nxt; // equality seen last cycle
  logic pend_r, pend_nxt; // timer a clear pending
  logic tac_r, tac_nxt; // timer a clear pulse
  logic trg_r, trg_nxt; // trigger pulse
  logic adc_r, adc_nxt; // conversion pulse
  logic irq_r, irq_nxt; // interrupt level
  logic out_r, out_nxt; // pin level
  logic oe_r, oe_nxt; // pin enable
  // decode
  logic [3:0] mode; // mode_select_field
  logic is_pwm; // pwm selected
  logic is_cmp; // any compare mode
  logic eq; // compare value equals timer a
  logic hit; // new match event
  logic [5:0] sub_lim; // sub counter wrap value
  logic [1:0] tb_lo; // low bits of next 10-bit time base

  assign mode = ctl_r[3:0];
  assign is_pwm = mode[3:2] == cuo_pkg::MD_PWM;
  assign is_cmp = mode == cuo_pkg::MD_TOG || mode[3:1] == cuo_pkg::MD_SET[3:1]
    || mode[3:1] == cuo_pkg::MD_SWI[3:1];
  // continuous 16-bit compare
  assign eq = timer_a_count == {cvh_r, cvl_r};
  // a match counts once, when equality starts; frozen in sleep
  assign hit = is_cmp && eq && !eqp_r && !sleep;

  // sub counter wrap by prescale
  always_comb begin
    case (tbc_r[1:0])
      2'h0: begin
        sub_lim = cuo_pkg::SUB_P1;
      end
      2'h1: begin
        sub_lim = cuo_pkg::SUB_P4;
      end
      default: begin
        sub_lim = cuo_pkg::SUB_P16;
      end
    endcase
  end

  // next state: registers, compare, timer b, pwm
  always_comb begin
    ctl_nxt = ctl_r;
    cvl_nxt = cvl_r;
    cvh_nxt = cvh_r;
    ien_nxt = ien_r;
    flg_nxt = flg_r;
    per_nxt = per_r;
    tbc_nxt = tbc_r;
    tmrb_nxt = tmrb_r;
    sub_nxt = sub_r;
    dlat_nxt = dlat_r;
    pwm_nxt = pwm_r;
    cmp_nxt = cmp_r;
    eqp_nxt = sleep ? eqp_r : eq;
    pend_nxt = pend_r;
    tac_nxt = 1'b0;
    trg_nxt = 1'b0;
    adc_nxt = 1'b0;
    tb_lo = 2'h0;
    rdata_nxt = cuo_pkg::RST_BYTE;
    // register reads, data in the following cycle
    if (rd) begin
      case (addr)
        cuo_pkg::ADR_CTL: rdata_nxt = ctl_r;
        cuo_pkg::ADR_CVL: rdata_nxt = cvl_r;
        cuo_pkg::ADR_CVH: rdata_nxt = cvh_r;
        cuo_pkg::ADR_IEN: rdata_nxt = ien_r;
        cuo_pkg::ADR_FLG: rdata_nxt = flg_r;
        cuo_pkg::ADR_PER: rdata_nxt = per_r;
        cuo_pkg::ADR_TBC: rdata_nxt = tbc_r;
        default: rdata_nxt = tmrb_r;
      endcase
    end
    // register writes; hardware sets below win over these
    if (wr) begin
      case (addr)
        cuo_pkg::ADR_CTL: begin
          ctl_nxt = wdata;
          if (wdata == cuo_pkg::RST_BYTE) begin
            cmp_nxt = 1'b0;
            pwm_nxt = 1'b0;
            pend_nxt = 1'b0;
          end
        end
        cuo_pkg::ADR_CVL: cvl_nxt = wdata;
        cuo_pkg::ADR_CVH: begin
          if (!is_pwm) begin
            cvh_nxt = wdata; // read only in pwm
          end
        end
        cuo_pkg::ADR_IEN: ien_nxt = wdata;
        cuo_pkg::ADR_FLG: flg_nxt = wdata; // software clears
        cuo_pkg::ADR_PER: per_nxt = wdata;
        cuo_pkg::ADR_TBC: tbc_nxt = wdata;
        default: tmrb_nxt = wdata;
      endcase
    end
    // compare match actions
    if (hit) begin
      flg_nxt[cuo_pkg::FLG_UNIT] = 1'b1;
      case (mode)
        cuo_pkg::MD_TOG: cmp_nxt = !cmp_r;
        cuo_pkg::MD_SET: cmp_nxt = 1'b1;
        cuo_pkg::MD_CLR: cmp_nxt = 1'b0;
        cuo_pkg::MD_TRG: begin
          trg_nxt = 1'b1;
          pend_nxt = 1'b1;
          adc_nxt = adc_enable;
        end
        default: cmp_nxt = cmp_r; // event only
      endcase
    end
    // pending timer a clear waits for the timer clock edge
    if (pend_r && !sleep) begin
      if (!eq) begin
        pend_nxt = 1'b0;
      end else if (timer_a_tick) begin
        tac_nxt = 1'b1;
        pend_nxt = 1'b0;
      end
    end
    // only a real rollover sets the overflow flag
    if (timer_a_ovf) begin
      flg_nxt[cuo_pkg::FLG_TA] = 1'b1;
    end
    // timer b: four phases per count times prescale
    if (tbc_r[cuo_pkg::TBC_ON] && !sleep) begin
      if (sub_r >= sub_lim) begin
        sub_nxt = 6'h00;
        if (tmrb_r == per_r) begin
          tmrb_nxt = 8'h00;
          flg_nxt[cuo_pkg::FLG_TB] = 1'b1;
          // outside pwm the high byte is the compare value, keep it
          if (is_pwm) begin
            cvh_nxt = cvl_r; // double buffer
            dlat_nxt = ctl_r[cuo_pkg::DLB_LO+:2];
          end
          pwm_nxt = {cvl_r, ctl_r[cuo_pkg::DLB_LO+:2]} != 10'h000;
        end else begin
          tmrb_nxt = tmrb_r + 8'h01;
        end
      end else begin
        sub_nxt = sub_r + 6'h01;
      end
      // low bits of the time base after this cycle, by prescale
      case (tbc_r[1:0])
        2'h0: tb_lo = sub_nxt[1:0];
        2'h1: tb_lo = sub_nxt[3:2];
        default: tb_lo = sub_nxt[5:4];
      endcase
      // pin drops in the first cycle the time base equals the duty
      if (is_pwm && {tmrb_nxt, tb_lo} == {cvh_nxt, dlat_nxt}) begin
        pwm_nxt = 1'b0;
      end
    end
    // pin drive follows the next mode; trigger and event modes float
    oe_nxt = ctl_nxt[3:2] == cuo_pkg::MD_PWM || ctl_nxt[3:0] == cuo_pkg::MD_TOG
      || ctl_nxt[3:1] == cuo_pkg::MD_SET[3:1];
    out_nxt = oe_nxt && (ctl_nxt[3:2] == cuo_pkg::MD_PWM ? pwm_nxt : cmp_nxt);
    irq_nxt = |(flg_nxt & ien_nxt);
  end

  // register every state bit; reset clears control
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctl_r <= cuo_pkg::RST_BYTE;
      cvl_r <= cuo_pkg::RST_BYTE;
      cvh_r <= cuo_pkg::RST_BYTE;
      ien_r <= cuo_pkg::RST_BYTE;
      flg_r <= cuo_pkg::RST_BYTE;
      per_r <= cuo_pkg::RST_PER;
      tbc_r <= cuo_pkg::RST_BYTE;
      rdata_r <= cuo_pkg::RST_BYTE;
      tmrb_r <= cuo_pkg::RST_BYTE;
      sub_r <= 6'h00;
      dlat_r <= 2'h0;
      pwm_r <= 1'b0;
      cmp_r <= 1'b0;
      eqp_r <= 1'b0;
      pend_r <= 1'b0;
      tac_r <= 1'b0;
      trg_r <= 1'b0;
      adc_r <= 1'b0;
      irq_r <= 1'b0;
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      cvl_r <= cvl_nxt;
      cvh_r <= cvh_nxt;
      ien_r <= ien_nxt;
      flg_r <= flg_nxt;
      per_r <= per_nxt;
      tbc_r <= tbc_nxt;
      rdata_r <= rdata_nxt;
      tmrb_r <= tmrb_nxt;
      sub_r <= sub_nxt;
      dlat_r <= dlat_nxt;
      pwm_r <= pwm_nxt;
      cmp_r <= cmp_nxt;
      eqp_r <= eqp_nxt;
      pend_r <= pend_nxt;
      tac_r <= tac_nxt;
      trg_r <= trg_nxt;
      adc_r <= adc_nxt;
      irq_r <= irq_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  // outputs straight from flip-flops
  assign rdata = rdata_r;
  assign timer_a_clear = tac_r;
  assign special_trigger = trg_r;
  assign adc_start = adc_r;
  assign unit_irq = irq_r;
  assign pin_out = out_r;
  assign pin_oe = oe_r;

  // checks on the unit's own outputs and registers
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  ctl_zero_a: assert property (
    wr && addr == cuo_pkg::ADR_CTL && wdata == 8'h00 |=> !cmp_r && !out_r)
    else $error("compare latch not low after zero control write");
  ctl_release_a: assert property (
    wr && addr == cuo_pkg::ADR_CTL && wdata == 8'h00 |=> !oe_r [*2])
    else $error("pin still driven after zero control write");
  swi_float_a: assert property (
    mode == cuo_pkg::MD_SWI && !wr |=> !oe_r && !trg_r)
    else $error("software event mode touched the pin");
  trg_float_a: assert property (
    mode == cuo_pkg::MD_TRG && !wr |=> !oe_r)
    else $error("trigger mode drove the pin");
  trg_pulse_a: assert property (
    hit && mode == cuo_pkg::MD_TRG |=> special_trigger ##1 !special_trigger)
    else $error("trigger pulse missing or too long");
  adc_gate_a: assert property (
    adc_start |-> special_trigger && $past(adc_enable))
    else $error("conversion request with converter disabled");
  ta_clear_a: assert property (
    timer_a_clear |-> $past(timer_a_tick) && $past(eq) && $past(pend_r))
    else $error("timer a cleared without edge and match");
  evt_flag_a: assert property (
    hit |=> flg_r[cuo_pkg::FLG_UNIT])
    else $error("match did not set the event flag");
  irq_gate_a: assert property (
    unit_irq |-> |(flg_r & ien_r))
    else $error("interrupt without an enabled flag");
  toggle_a: assert property (
    hit && mode == cuo_pkg::MD_TOG && !wr |=> cmp_r != $past(cmp_r) ##1 out_r == $past(cmp_r))
    else $error("toggle not applied within a cycle");
  sleep_hold_a: assert property (
    sleep && !pend_r |=> !special_trigger && !timer_a_clear)
    else $error("compare action while asleep");
endmodule : cuo_unit
`default_nettype wire

// ---- cuo_load.sv ----
// pin load model: resolves the unit pin and counts high cycles
`timescale 1ns/1ns
`default_nettype none
module cuo_load (
  input wire logic clock, // system clock
  input wire logic pin_out, // unit pin level
  input wire logic pin_oe, // unit drives pin
  input wire logic cnt_clr, // restart high count
  output logic pin_level, // resolved pin level
  output var int high_cnt // high cycles since clear
);
  // a released pin falls to the pull-down level
  assign pin_level = pin_oe ? pin_out : 1'b0;
  // count cycles with the pin high
  always @(posedge clock) begin
    if (cnt_clr) begin
      high_cnt <= 0;
    end else if (pin_level === 1'b1) begin
      high_cnt <= high_cnt + 1;
    end
  end
endmodule : cuo_load
`default_nettype wire

// ---- cuo_unit_test.sv ----
// self-checking bench for the compare and pwm output unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module cuo_unit_test;
  logic clock = 1'b0; // system clock
  logic rst_n = 1'b0; // reset, active low
  logic [2:0] addr = 3'h0; // register index
  logic [7:0] wdata = 8'h00; // write data
  logic wr = 1'b0; // write strobe
  logic rd = 1'b0; // read strobe
  logic [15:0] ta_cnt = 16'h0000; // timer a count
  logic ta_tick = 1'b0; // timer a edge
  logic ta_ovf = 1'b0; // timer a rollover
  logic adc_en = 1'b0; // converter enabled
  logic sleep = 1'b0; // clock stopped
  logic cnt_clr = 1'b1; // load count restart
  logic [7:0] rdata; // read data
  logic ta_clr, trig, adc_go, irq, pin_out, pin_oe, pin_lvl; // unit outputs and load pin level
  int high_cnt; // pin high cycles
  int fails = 0; // mismatches
  int cmp_count = 0; // comparisons
  logic [7:0] d; // last read value
  logic [3:0] md [3] = '{cuo_pkg::MD_SET, cuo_pkg::MD_CLR, cuo_pkg::MD_TOG}; // modes
  logic pv [3] = '{1'b1, 1'b0, 1'b1}; // pin after each match
  // 125 MHz clock
  always #4 clock = ~clock;
  cuo_unit cuo_unit_i (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .timer_a_count(ta_cnt), .timer_a_tick(ta_tick),
    .timer_a_ovf(ta_ovf), .adc_enable(adc_en), .sleep(sleep), .timer_a_clear(ta_clr),
    .special_trigger(trig), .adc_start(adc_go), .unit_irq(irq), .pin_out(pin_out),
    .pin_oe(pin_oe));
  cuo_load cuo_load_i (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .cnt_clr(cnt_clr), .pin_level(pin_lvl), .high_cnt(high_cnt));
  // one-cycle register write
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  // one-cycle read, data taken the cycle after
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask : rd_reg
  // fresh rising equality, then look one cycle on
  task automatic hit(input logic [15:0] v);
    @(posedge clock);
    ta_cnt <= 16'h0000;
    @(posedge clock);
    ta_cnt <= v;
    @(posedge clock);
    @(negedge clock);
  endtask : hit
  // timer a edge, clear expected the next cycle or not
  task automatic tick(input logic exp);
    @(posedge clock);
    ta_tick <= 1'b1;
    @(posedge clock);
    ta_tick <= 1'b0;
    @(negedge clock);
    `CHK(ta_clr, exp)
  endtask : tick
  // settle, then count pin high cycles over 128 cycles
  task automatic meas(input int exp);
    repeat (128) @(posedge clock);
    cnt_clr <= 1'b1;
    @(posedge clock);
    cnt_clr <= 1'b0;
    repeat (128) @(posedge clock);
    @(negedge clock);
    `CHK(high_cnt, exp)
  endtask : meas
  // verdict and end of run
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // watchdog well beyond the expected run length
  initial begin
    repeat (6000) @(posedge clock);
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test;
  end
  // test sequence
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_reg(3'(i), d);
      `CHK(d, (i == 5) ? cuo_pkg::RST_PER : cuo_pkg::RST_BYTE)
    end
    `CHK({pin_oe, pin_out, trig, adc_go, irq, ta_clr}, 6'h00)
    $display("test reset done");
    wr_reg(cuo_pkg::ADR_CVL, 8'h34);
    wr_reg(cuo_pkg::ADR_CVH, 8'h12);
    wr_reg(cuo_pkg::ADR_IEN, 8'h04);
    for (int i = 0; i < 3; i++) begin
      wr_reg(cuo_pkg::ADR_CTL, {4'h0, md[i]});
      hit(16'h1234);
      `CHK({pin_oe, pin_out}, {1'b1, pv[i]})
    end
    `CHK(irq, 1'b1)
    rd_reg(cuo_pkg::ADR_FLG, d);
    `CHK(d, 8'h04)
    wr_reg(cuo_pkg::ADR_IEN, 8'h00);
    repeat (2) @(negedge clock);
    `CHK(irq, 1'b0)
    rd_reg(cuo_pkg::ADR_FLG, d);
    `CHK(d, 8'h04)
    wr_reg(cuo_pkg::ADR_CTL, 8'h00);
    repeat (2) @(negedge clock);
    `CHK({pin_oe, pin_out}, 2'b00)
    $display("test compare done");
    wr_reg(cuo_pkg::ADR_FLG, 8'h00);
    wr_reg(cuo_pkg::ADR_CTL, {4'h0, cuo_pkg::MD_SWI});
    hit(16'h1235);
    rd_reg(cuo_pkg::ADR_FLG, d);
    `CHK(d, 8'h00)
    hit(16'h1234);
    `CHK({pin_oe, pin_out}, 2'b00)
    rd_reg(cuo_pkg::ADR_FLG, d);
    `CHK(d, 8'h04)
    wr_reg(cuo_pkg::ADR_FLG, 8'h00);
    sleep <= 1'b1;
    hit(16'h1234);
    @(posedge clock);
    sleep <= 1'b0;
    rd_reg(cuo_pkg::ADR_FLG, d);
    `CHK(d, 8'h00)
    $display("test event done");
    wr_reg(cuo_pkg::ADR_CTL, {4'h0, cuo_pkg::MD_TRG});
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      adc_en <= (k == 0);
      hit(16'h1234);
      `CHK({trig, adc_go, pin_oe}, {1'b1, k == 0, 1'b0})
      tick(1'b1);
    end
    rd_reg(cuo_pkg::ADR_FLG, d);
    `CHK(d, 8'h04)
    @(posedge clock);
    ta_ovf <= 1'b1;
    @(posedge clock);
    ta_ovf <= 1'b0;
    rd_reg(cuo_pkg::ADR_FLG, d);
    `CHK(d, 8'h05)
    hit(16'h1234);
    wr_reg(cuo_pkg::ADR_CVL, 8'h35);
    tick(1'b0);
    $display("test trigger done");
    wr_reg(cuo_pkg::ADR_CTL, 8'h00);
    wr_reg(cuo_pkg::ADR_PER, 8'h00);
    wr_reg(cuo_pkg::ADR_CVL, 8'h00);
    wr_reg(cuo_pkg::ADR_CTL, 8'h2c);
    for (int p = 0; p < 3; p++) begin
      wr_reg(cuo_pkg::ADR_TBC, 8'h04 | 8'(p));
      meas(64);
    end
    wr_reg(cuo_pkg::ADR_CTL, 8'h0c);
    meas(0);
    rd_reg(cuo_pkg::ADR_FLG, d);
    `CHK(d & 8'h02, 8'h02)
    wr_reg(cuo_pkg::ADR_CTL, 8'h00);
    repeat (2) @(negedge clock);
    `CHK(pin_oe, 1'b0)
    $display("test pwm done");
    finish_test;
  end
endmodule : cuo_unit_test
`default_nettype wire
